// ### core/psh_defs.vh
// Constants for the program synchronization and hold logic.
`ifndef PSH_DEFS_VH
`define PSH_DEFS_VH
`define PSH_CODE_OFF 16'h0000
`define PSH_DI_STD_BASE 16'd5025
`define PSH_DI_E1_BASE 16'd5041
`define PSH_DI_E4_BASE 16'd5089
`define PSH_STD_COUNT 3
`define PSH_AREA_COUNT 5
`define PSH_FN_SEGFLAG 16'd4261
`define PSH_FN_WAITFLAG 16'd4190
`define PSH_AREA_E1 3'h1
`define PSH_AREA_E4 3'h4
`define PSH_DELAY_S 5
`define PSH_FORCE_OFF_S 1
`define PSH_CLK_HZ 20000000
`define PSH_ADDR_WAITSEL 12'h000
`define PSH_ADDR_HOLDSEL 12'h004
`define PSH_ADDR_WAITCFG 12'h008
`define PSH_ADDR_ZONE 12'h00c
`define PSH_ADDR_ALMFN 12'h010
`define PSH_ADDR_RLYFN 12'h014
`define PSH_ADDR_DO1FN 12'h018
`define PSH_ADDR_DO4FN 12'h01c
`define PSH_ADDR_PROG 12'h020
`define PSH_ADDR_STATUS 12'h024
`define PSH_ADDR_DOFN_STRIDE 12'h008
`define PSH_HTRANS_NONSEQ 2'h2
`endif

// ### core/psh_out_route.v
// Output router: maps a function code to the segment or wait flag.
`timescale 1ns/1ps
`include "psh_defs.vh"
module psh_out_route #(
    parameter N = 10
) (
    input wire clk,
    input wire rst_n,
    input wire [16*N-1:0] fnCodes,
    input wire segFlag,
    input wire waitFlag,
    output reg [N-1:0] outs
);
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : gRoute
            wire [15:0] code = fnCodes[16*i +: 16];
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    outs[i] <= 1'b0;
                end else begin
                    outs[i] <= ((code == `PSH_FN_SEGFLAG) & segFlag) |
                               ((code == `PSH_FN_WAITFLAG) & waitFlag);
                end
            end
        end
    endgenerate
endmodule // psh_out_route

// ### core/psh_sync_hold.v
// Top of the program synchronization and hold logic with AHB-Lite registers.
`timescale 1ns/1ps
`include "psh_defs.vh"
module psh_sync_hold #(
    parameter integer CLK_HZ = `PSH_CLK_HZ,
    parameter integer STARTUP_CYCLES = `PSH_DELAY_S * `PSH_CLK_HZ,
    parameter integer SECOND_CYCLES = `PSH_CLK_HZ
) (
    input wire clk,
    input wire rst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [2:0] contactStd,
    input wire [4:0] contactE1,
    input wire [4:0] contactE4,
    input wire [15:0] processValue,
    output reg [2:0] alarmOut,
    output reg [1:0] relayOut,
    output reg [4:0] digitalOutE1,
    output reg [4:0] digitalOutE4,
    output reg progRunning,
    output reg holdActive,
    output reg segmentTick
);
    localparam ST_BOOT = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_HOLD = 3'b100;
    // =====================================================================
    // Contact decode
    function contact_level;
        input [15:0] code;
        input [2:0] stdIn;
        input [4:0] e1In;
        input [4:0] e4In;
        reg [15:0] off;
        begin
            contact_level = 1'b0;
            if (code >= `PSH_DI_STD_BASE && code < `PSH_DI_STD_BASE + `PSH_STD_COUNT) begin
                off = code - `PSH_DI_STD_BASE;
                contact_level = stdIn[off[1:0]];
            end else if (code >= `PSH_DI_E1_BASE && code < `PSH_DI_E1_BASE + `PSH_AREA_COUNT) begin
                off = code - `PSH_DI_E1_BASE;
                contact_level = e1In[off[2:0]];
            end else if (code >= `PSH_DI_E4_BASE && code < `PSH_DI_E4_BASE + `PSH_AREA_COUNT) begin
                off = code - `PSH_DI_E4_BASE;
                contact_level = e4In[off[2:0]];
            end
        end
    endfunction
    // =====================================================================
    // Registers
    reg [15:0] waitSel_q;
    reg [15:0] holdSel_q;
    reg waitEnable_q;
    reg [15:0] zoneUpper_q;
    reg [15:0] zoneLower_q;
    reg [47:0] almFn_q;
    reg [31:0] rlyFn_q;
    reg [79:0] do1Fn_q;
    reg [79:0] do4Fn_q;
    reg runCmd_q;
    reg [15:0] segSeconds_q;
    reg segLoad_q;
    reg [11:0] addr_q;
    reg wr_q;
    wire accept = hsel & hready & (htrans == `PSH_HTRANS_NONSEQ);
    wire [11:0] wAddr = addr_q;
    // Read data is registered at the address phase so it stands in the data phase with no wait state.
    // A read straight after a write to the same register would return the old value; the bus idles between them.
    wire [11:0] rAddr = {haddr[11:2], 2'b00};
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= 12'h000;
            wr_q <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_q <= accept & hwrite;
            if (accept) begin
                addr_q <= {haddr[11:2], 2'b00};
            end
        end
    end
    // Writes land in the data phase; DO fields are 16 bits, two per word, packed low first.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitSel_q <= `PSH_CODE_OFF;
            holdSel_q <= `PSH_CODE_OFF;
            waitEnable_q <= 1'b0;
            zoneUpper_q <= 16'h0000;
            zoneLower_q <= 16'h0000;
            almFn_q <= 48'h0000_0000_0000;
            rlyFn_q <= 32'h0000_0000;
            do1Fn_q <= 80'h0000_0000_0000_0000_0000;
            do4Fn_q <= 80'h0000_0000_0000_0000_0000;
            runCmd_q <= 1'b0;
            segSeconds_q <= 16'h0000;
            segLoad_q <= 1'b0;
        end else begin
            segLoad_q <= 1'b0;
            if (wr_q) begin
                case (wAddr)
                    `PSH_ADDR_WAITSEL: waitSel_q <= hwdata[15:0];
                    `PSH_ADDR_HOLDSEL: holdSel_q <= hwdata[15:0];
                    `PSH_ADDR_WAITCFG: waitEnable_q <= hwdata[0];
                    `PSH_ADDR_ZONE: begin
                        zoneLower_q <= hwdata[15:0];
                        zoneUpper_q <= hwdata[31:16];
                    end
                    `PSH_ADDR_ALMFN: almFn_q[31:0] <= hwdata;
                    `PSH_ADDR_RLYFN: rlyFn_q <= hwdata;
                    `PSH_ADDR_DO1FN: do1Fn_q[31:0] <= hwdata;
                    `PSH_ADDR_DO4FN: do4Fn_q[31:0] <= hwdata;
                    `PSH_ADDR_PROG: begin
                        runCmd_q <= hwdata[0];
                        if (hwdata[1]) begin
                            segSeconds_q <= hwdata[31:16];
                            segLoad_q <= 1'b1;
                        end
                    end
                    `PSH_ADDR_ALMFN + 12'h040: almFn_q[47:32] <= hwdata[15:0];
                    `PSH_ADDR_DO1FN + 12'h040: do1Fn_q[63:32] <= hwdata;
                    `PSH_ADDR_DO1FN + 12'h040 + `PSH_ADDR_DOFN_STRIDE: do1Fn_q[79:64] <= hwdata[15:0];
                    `PSH_ADDR_DO4FN + 12'h040: do4Fn_q[63:32] <= hwdata;
                    `PSH_ADDR_DO4FN + 12'h040 + `PSH_ADDR_DOFN_STRIDE: do4Fn_q[79:64] <= hwdata[15:0];
                    default: begin
                    end
                endcase
            end
        end
    end
    // =====================================================================
    // Timing and program state
    reg [2:0] state_q;
    reg [31:0] bootCnt_q;
    reg [31:0] secCnt_q;
    reg [15:0] remain_q;
    reg [31:0] forceCnt_q;
    reg waitFlag_q;
    reg segFlag_q;
    wire secTick = (secCnt_q == SECOND_CYCLES - 1);
    wire holdEn = (holdSel_q != `PSH_CODE_OFF);
    // Hold input is a level; the shared line is the wired-OR of every wait flag.
    wire holdSeen = holdEn & contact_level(holdSel_q, contactStd, contactE1, contactE4);
    wire waitIn = (waitSel_q != `PSH_CODE_OFF) & contact_level(waitSel_q, contactStd, contactE1, contactE4);
    wire inZone = (processValue >= zoneLower_q) & (processValue <= zoneUpper_q);
    // Wait within the interval needs the first wait group and a PV outside the zone.
    wire waitCond = waitEnable_q & ~inZone & (state_q != ST_BOOT);
    wire segEnd = (remain_q == 16'h0000);
    wire advance = (state_q == ST_RUN) & runCmd_q & secTick & ~waitCond & ~waitIn & ~segEnd;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_BOOT;
            bootCnt_q <= 32'h0000_0000;
            secCnt_q <= 32'h0000_0000;
            remain_q <= 16'h0000;
            forceCnt_q <= 32'h0000_0000;
            waitFlag_q <= 1'b0;
            segFlag_q <= 1'b0;
            segmentTick <= 1'b0;
        end else begin
            secCnt_q <= secTick ? 32'h0000_0000 : secCnt_q + 32'h0000_0001;
            segmentTick <= 1'b0;
            waitFlag_q <= runCmd_q & waitCond;
            case (state_q)
                ST_BOOT: begin
                    // Hold select is off out of reset, so every unit leaves boot on the first clock and the start lag is never paid.
                    if (!holdEn || bootCnt_q == STARTUP_CYCLES - 1) begin
                        state_q <= ST_RUN;
                    end else begin
                        bootCnt_q <= bootCnt_q + 32'h0000_0001;
                    end
                end
                ST_RUN: begin
                    if (holdSeen & runCmd_q) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (!holdSeen) begin
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_BOOT;
            endcase
            if (segLoad_q) begin
                remain_q <= segSeconds_q;
            end else if (advance) begin
                remain_q <= remain_q - 16'h0001;
                if (remain_q == 16'h0001) begin
                    segmentTick <= 1'b1;
                    forceCnt_q <= SECOND_CYCLES;
                end
            end
            if (forceCnt_q != 32'h0000_0000) begin
                forceCnt_q <= forceCnt_q - 32'h0000_0001;
            end
            // Off also when not running or the wait switch is off.
            segFlag_q <= runCmd_q & waitEnable_q & (forceCnt_q == 32'h0000_0000) &
                         ((waitCond | waitIn) | ~segEnd);
        end
    end
    // =====================================================================
    // Outputs
    wire [2:0] almW;
    wire [1:0] rlyW;
    wire [4:0] do1W;
    wire [4:0] do4W;
    psh_out_route #(.N(15)) uRoute (
        .clk(clk),
        .rst_n(rst_n),
        .fnCodes({do4Fn_q, do1Fn_q, rlyFn_q, almFn_q}),
        .segFlag(segFlag_q),
        .waitFlag(waitFlag_q),
        .outs({do4W, do1W, rlyW, almW})
    );
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarmOut <= 3'h0;
            relayOut <= 2'h0;
            digitalOutE1 <= 5'h00;
            digitalOutE4 <= 5'h00;
            progRunning <= 1'b0;
            holdActive <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            alarmOut <= almW;
            relayOut <= rlyW;
            digitalOutE1 <= do1W;
            digitalOutE4 <= do4W;
            progRunning <= (state_q == ST_RUN) & runCmd_q;
            holdActive <= (state_q == ST_HOLD);
            hrdata <= 32'h0000_0000;
            if (accept & ~hwrite) begin
                case (rAddr)
                    `PSH_ADDR_WAITSEL: hrdata <= {16'h0000, waitSel_q};
                    `PSH_ADDR_HOLDSEL: hrdata <= {16'h0000, holdSel_q};
                    `PSH_ADDR_WAITCFG: hrdata <= {31'h0000_0000, waitEnable_q};
                    `PSH_ADDR_ZONE: hrdata <= {zoneUpper_q, zoneLower_q};
                    `PSH_ADDR_ALMFN: hrdata <= almFn_q[31:0];
                    `PSH_ADDR_RLYFN: hrdata <= rlyFn_q;
                    `PSH_ADDR_DO1FN: hrdata <= do1Fn_q[31:0];
                    `PSH_ADDR_DO4FN: hrdata <= do4Fn_q[31:0];
                    `PSH_ADDR_PROG: hrdata <= {segSeconds_q, 15'h0000, runCmd_q};
                    `PSH_ADDR_STATUS: hrdata <= {remain_q, 10'h000, segFlag_q, waitFlag_q, state_q, 1'b0};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // psh_sync_hold

// ### tb/psh_sync_hold_props.sv
// Port checker for the synchronization and hold logic.
`timescale 1ns/1ps
module psh_sync_hold_props (
    input wire clk,
    input wire rst_n,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [2:0] contactStd,
    input wire [4:0] contactE1,
    input wire [4:0] contactE4,
    input wire progRunning,
    input wire holdActive,
    input wire segmentTick
);
    // Read data may stand only in the cycle after an accepted read.
    reg rdPhase_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) rdPhase_q <= 1'b0;
        else rdPhase_q <= hsel && hready && htrans == 2'h2 && !hwrite;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_READY: assert property (hreadyout && !hresp) else $error("bus answer not ready and okay");
    AST_RDIDLE: assert property (!rdPhase_q |-> hrdata == 32'h0000_0000) else $error("read data outside data phase");
    AST_HOLD_EXCL: assert property (holdActive |-> !progRunning) else $error("running while held");
    AST_HOLD_ENTRY: assert property ($rose(holdActive) |-> $past(progRunning)) else $error("hold not from run");
    AST_HOLD_CAUSE: assert property ($rose(holdActive) |-> $past(|{contactStd, contactE1, contactE4}))
        else $error("hold without contact level");
    AST_TICK_PULSE: assert property (segmentTick |=> !segmentTick) else $error("tick longer than a cycle");
    AST_TICK_RUN: assert property (segmentTick |-> $past(progRunning)) else $error("tick while not running");
    AST_TICK_HELD: assert property (holdActive [*2] |-> !segmentTick) else $error("time advanced in hold");
endmodule // psh_sync_hold_props
bind psh_sync_hold psh_sync_hold_props u_props (.clk(clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .contactStd(contactStd), .contactE1(contactE1), .contactE4(contactE4), .progRunning(progRunning),
    .holdActive(holdActive), .segmentTick(segmentTick));

// ### tb/psh_peer_model.sv
// Peer controller model sharing the wired-OR hold line.
`timescale 1ns/1ps
module psh_peer_model (
    input wire clk,
    input wire rst_n,
    input wire ownFlag,
    input wire peerWait,
    output wire syncLine
);
    // The peer changes its flag only on its own clock edge, like a real controller.
    reg peerFlag_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) peerFlag_q <= 1'b0;
        else peerFlag_q <= peerWait;
    end
    assign syncLine = ownFlag | peerFlag_q;
endmodule // psh_peer_model

// ### tb/psh_sync_hold_bench.sv
// Self-checking bench for the synchronization and hold logic.
`timescale 1ns/1ps
`include "psh_defs.vh"
module psh_sync_hold_bench;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0000_0000;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0000_0000;
    reg [15:0] processValue = 16'h0096;
    reg peerWait = 1'b0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, progRunning, holdActive, segmentTick, syncLine;
    wire [2:0] alarmOut;
    wire [1:0] relayOut;
    wire [4:0] digitalOutE1, digitalOutE4;
    integer fail_count = 0;
    integer checks_done = 0;
    integer cyc = 0;
    integer n;
    reg [31:0] r1, r2;
    // Short second and startup counts keep the run brief.
    psh_sync_hold #(.STARTUP_CYCLES(20), .SECOND_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .contactStd({syncLine, 2'b00}),
        .contactE1(5'h00), .contactE4(5'h00), .processValue(processValue), .alarmOut(alarmOut),
        .relayOut(relayOut), .digitalOutE1(digitalOutE1), .digitalOutE4(digitalOutE4),
        .progRunning(progRunning), .holdActive(holdActive), .segmentTick(segmentTick));
    psh_peer_model u_peer (.clk(clk), .rst_n(rst_n), .ownFlag(alarmOut[0]), .peerWait(peerWait),
        .syncLine(syncLine));
    initial forever #25 clk = ~clk;
    // ==========================================
    // Tasks.
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task bus(input wr, input [31:0] a, input [31:0] d, output [31:0] q);
        begin
            hsel <= 1'b1;
            haddr <= a;
            hwrite <= wr;
            htrans <= `PSH_HTRANS_NONSEQ;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            htrans <= 2'h0;
            hsel <= 1'b0;
            hwdata <= d;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            q = hrdata;
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        bus(1'b1, a, d, r2);
    endtask
    task rdc(input [31:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0000_0000, r2);
            chk(r2, e);
        end
    endtask
    task cy(input integer k);
        repeat (k) @(posedge clk);
    endtask
    task tdone(input [8*8-1:0] s);
        $display("test %0s done", s);
    endtask
    // A hang in any wait ends the run as a mismatch.
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            fail_count = fail_count + 1;
            report_and_stop;
        end
    end
    // ==========================================
    // Tests.
    initial begin
        cy(6);
        rst_n <= 1'b1;
        cy(1);
        rdc(`PSH_ADDR_WAITSEL, 32'h0000_0000);
        rdc(`PSH_ADDR_HOLDSEL, 32'h0000_0000);
        wr(32'h0000_0100, 32'hffff_ffff);
        rdc(32'h0000_0100, 32'h0000_0000);
        tdone("reset");
        wr(`PSH_ADDR_HOLDSEL, 32'h0000_13a3);
        wr(`PSH_ADDR_WAITCFG, 32'h0000_0001);
        wr(`PSH_ADDR_ZONE, 32'h00c8_0064);
        wr(`PSH_ADDR_ALMFN, {`PSH_FN_SEGFLAG, `PSH_FN_WAITFLAG});
        wr(`PSH_ADDR_RLYFN, {16'h0000, `PSH_FN_SEGFLAG});
        wr(`PSH_ADDR_DO1FN, {16'h0000, `PSH_FN_SEGFLAG});
        wr(`PSH_ADDR_DO4FN, {16'h0000, `PSH_FN_WAITFLAG});
        rdc(`PSH_ADDR_HOLDSEL, 32'h0000_13a3);
        wr(`PSH_ADDR_PROG, 32'h0005_0003);
        cy(5);
        chk({alarmOut, relayOut[0], digitalOutE1[0]}, 5'b01011);
        n = 0;
        while (segmentTick !== 1'b1 && n < 60) begin
            @(posedge clk);
            n = n + 1;
        end
        chk(n >= 12 && n <= 24, 1'b1);
        cy(3);
        chk(alarmOut[1], 1'b0);
        tdone("segment");
        wr(`PSH_ADDR_PROG, 32'h0005_0003);
        processValue <= 16'h0032;
        cy(6);
        chk({alarmOut[0], digitalOutE4[0], holdActive, progRunning}, 4'b1110);
        processValue <= 16'h0096;
        cy(6);
        chk({alarmOut[0], holdActive, progRunning}, 3'b001);
        wr(`PSH_ADDR_PROG, 32'h0005_0003);
        peerWait <= 1'b1;
        cy(3);
        bus(1'b0, `PSH_ADDR_STATUS, 32'h0000_0000, r1);
        cy(12);
        bus(1'b0, `PSH_ADDR_STATUS, 32'h0000_0000, r2);
        chk(r2[31:16], r1[31:16]);
        chk({holdActive, r1[3:1]}, 4'b1100);
        peerWait <= 1'b0;
        cy(4);
        chk(progRunning, 1'b1);
        tdone("hold");
        wr(`PSH_ADDR_WAITCFG, 32'h0000_0000);
        processValue <= 16'h0032;
        cy(6);
        chk({alarmOut[0], holdActive}, 2'b00);
        wr(`PSH_ADDR_HOLDSEL, 32'h0000_0000);
        peerWait <= 1'b1;
        cy(6);
        chk(holdActive, 1'b0);
        tdone("select");
        report_and_stop;
    end
endmodule // psh_sync_hold_bench
